// *** src/cnb_pkg.sv ***
package cnb_pkg;
  localparam logic [7:0]  OFF_NODE_OBJ  = 8'h00;
  localparam logic [7:0]  OFF_BAUD_OBJ  = 8'h04;
  localparam logic [7:0]  OFF_STORE     = 8'h08;
  localparam logic [7:0]  OFF_CTRL      = 8'h0c;
  localparam logic [7:0]  OFF_ACTIVE    = 8'h10;
  localparam logic [7:0]  OFF_REQ_LO    = 8'h14;
  localparam logic [7:0]  OFF_REQ_HI    = 8'h18;
  localparam logic [7:0]  OFF_STATUSW   = 8'h1c;
  localparam logic [7:0]  OFF_RESP_LO   = 8'h20;
  localparam logic [7:0]  OFF_RESP_HI   = 8'h24;
  localparam int          CTRL_RESET_B  = 0;
  localparam int          CTRL_FILE_B   = 1;
  localparam int          CTRL_FNODE_LS = 8;
  localparam int          CTRL_FBAUD_LS = 16;
  localparam logic [31:0] STORE_SIGN    = 32'h65766173;
  localparam logic [6:0]  DFLT_NODE     = 7'h01;
  localparam logic [7:0]  DFLT_BAUD     = 8'h88;
  localparam logic [9:0]  KBD_1M        = 10'h3e8;
  localparam logic [7:0]  SEL_SPLIT     = 8'h80;
  localparam logic [31:0] SDO_RD_STATUS = 32'h0060414b;
  localparam logic [31:0] SDO_REQ_STAT  = 32'h00604140;
  localparam logic [1:0]  SETTLE_CYC    = 2'h3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// *** src/cnb_top.sv ***
// Contract
// - Without stored, file or switch override the node id is 1 and the rate is 1 Mbaud.
// - The selector is upper switch in bits 7:4 and lower switch in bits 3:0.
// - The upper switch reading is weighted by sixteen before the lower one is added.
// - Selector 1 to 127 is the node id itself and the rate is fixed at 1 Mbaud.
// - Selector 129 to 255 gives node id selector minus 128 and the rate from the baud object.
// - Selector 0 takes the node object and 1 Mbaud; selector 128 takes both objects.
// - Baud codes 129 to 134 and 136 mean 10, 20, 50, 125, 250, 500 and 1000 kBd.
// - New settings apply only at power-up or on a communication reset.
// - Load order is default, stored value, configuration file, then switches.
// - A statusword read 40 41 60 00 0 0 0 0 is answered 4B 41 60 00, status, 00 00.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module cnb_top (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [3:0]  upper_digit_switch,
  input  wire logic [3:0]  lower_digit_switch,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [6:0]       node_id,
  output logic [9:0]       bit_rate_kbd,
  output logic             cfg_valid
);
  typedef struct packed {
    logic [7:0]  sw_meta;
    logic [7:0]  sw_sync;
    logic [1:0]  settle;
    logic [6:0]  node_obj;
    logic [7:0]  baud_obj;
    logic [6:0]  stored_node;
    logic [7:0]  stored_baud;
    logic        stored_ok;
    logic        file_ok;
    logic [6:0]  file_node;
    logic [7:0]  file_baud;
    logic [31:0] req_lo;
    logic [31:0] req_hi;
    logic [15:0] statusw;
    logic [31:0] resp_lo;
    logic [31:0] resp_hi;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [6:0]  node;
    logic [7:0]  baud;
    logic [9:0]  kbd;
    logic        valid;
  } cnb_state_t;

  localparam cnb_state_t RST = '{settle: cnb_pkg::SETTLE_CYC, default: '0};

  cnb_state_t st_r;
  cnb_state_t st_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Unlisted codes return 1 Mbaud so the node stays reachable.
  function automatic logic [9:0] decode_kbd(input logic [7:0] code);
    case (code)
      8'h81:   decode_kbd = 10'h00a;
      8'h82:   decode_kbd = 10'h014;
      8'h83:   decode_kbd = 10'h032;
      8'h84:   decode_kbd = 10'h07d;
      8'h85:   decode_kbd = 10'h0fa;
      8'h86:   decode_kbd = 10'h1f4;
      8'h88:   decode_kbd = 10'h3e8;
      default: decode_kbd = cnb_pkg::KBD_1M;
    endcase
  endfunction

  logic [7:0]  sel;
  logic [6:0]  lay_node;
  logic [7:0]  lay_baud;
  logic        apply;
  logic        wr_go;
  logic [31:0] ctrl_q;
  logic [31:0] rd_val;
  logic        rd_hit;

  always_comb begin
    sel = {st_r.sw_sync[7:4], 4'h0} + {4'h0, st_r.sw_sync[3:0]};
    lay_node = cnb_pkg::DFLT_NODE;
    lay_baud = cnb_pkg::DFLT_BAUD;
    if (st_r.stored_ok) begin
      lay_node = st_r.stored_node;
      lay_baud = st_r.stored_baud;
    end
    if (st_r.file_ok) begin
      lay_node = st_r.file_node;
      lay_baud = st_r.file_baud;
    end
    apply = (st_r.settle == 2'h1);
    wr_go = st_r.aw_full && st_r.w_full && !st_r.bvalid;
    ctrl_q = {8'h00, st_r.file_baud, 1'b0, st_r.file_node, 6'h00, st_r.file_ok, 1'b0};
    rd_hit = 1'b1;
    case (s_axi_araddr)
      cnb_pkg::OFF_NODE_OBJ: rd_val = {25'h0, st_r.node_obj};
      cnb_pkg::OFF_BAUD_OBJ: rd_val = {24'h0, st_r.baud_obj};
      cnb_pkg::OFF_STORE:    rd_val = {31'h0, st_r.stored_ok};
      cnb_pkg::OFF_CTRL:     rd_val = ctrl_q;
      cnb_pkg::OFF_ACTIVE:   rd_val = {st_r.kbd, 5'h0, st_r.valid, st_r.baud, 1'b0, st_r.node};
      cnb_pkg::OFF_REQ_LO:   rd_val = st_r.req_lo;
      cnb_pkg::OFF_REQ_HI:   rd_val = st_r.req_hi;
      cnb_pkg::OFF_STATUSW:  rd_val = {16'h0, st_r.statusw};
      cnb_pkg::OFF_RESP_LO:  rd_val = st_r.resp_lo;
      cnb_pkg::OFF_RESP_HI:  rd_val = st_r.resp_hi;
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.sw_meta = {upper_digit_switch, lower_digit_switch};
    st_nxt.sw_sync = st_r.sw_meta;
    if (st_r.settle != 2'h0) begin
      st_nxt.settle = st_r.settle - 2'h1;
    end
    // Node id, rate and valid change only here, at power-up or on a communication reset.
    if (apply) begin
      st_nxt.valid = 1'b1;
      if (sel == 8'h00) begin
        st_nxt.node = lay_node;
        st_nxt.baud = cnb_pkg::DFLT_BAUD;
      end else if (sel < cnb_pkg::SEL_SPLIT) begin
        st_nxt.node = sel[6:0];
        st_nxt.baud = cnb_pkg::DFLT_BAUD;
      end else if (sel == cnb_pkg::SEL_SPLIT) begin
        st_nxt.node = lay_node;
        st_nxt.baud = lay_baud;
      end else begin
        st_nxt.node = sel[6:0];
        st_nxt.baud = lay_baud;
      end
      st_nxt.kbd = decode_kbd(st_nxt.baud);
    end
    // The answer is rebuilt every cycle, so it follows the current request one clock later.
    if (st_r.req_lo == cnb_pkg::SDO_REQ_STAT && st_r.req_hi == 32'h0) begin
      st_nxt.resp_lo = cnb_pkg::SDO_RD_STATUS;
      st_nxt.resp_hi = {16'h0, st_r.statusw};
    end else begin
      st_nxt.resp_lo = 32'h0;
      st_nxt.resp_hi = 32'h0;
    end
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_full = 1'b1;
      st_nxt.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_full = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_nxt.aw_full = 1'b0;
      st_nxt.w_full = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = cnb_pkg::RESP_OKAY;
      case (st_r.waddr)
        cnb_pkg::OFF_NODE_OBJ:
          st_nxt.node_obj = 7'(merge({25'h0, st_r.node_obj}, st_r.wdata, st_r.wstrb));
        cnb_pkg::OFF_BAUD_OBJ:
          st_nxt.baud_obj = 8'(merge({24'h0, st_r.baud_obj}, st_r.wdata, st_r.wstrb));
        cnb_pkg::OFF_STORE: begin
          if (st_r.wdata == cnb_pkg::STORE_SIGN && st_r.wstrb == 4'hf) begin
            st_nxt.stored_node = st_r.node_obj;
            st_nxt.stored_baud = st_r.baud_obj;
            st_nxt.stored_ok = 1'b1;
          end
        end
        cnb_pkg::OFF_CTRL: begin
          st_nxt.file_ok = 1'(merge(ctrl_q, st_r.wdata, st_r.wstrb) >> cnb_pkg::CTRL_FILE_B);
          st_nxt.file_node = 7'(merge(ctrl_q, st_r.wdata, st_r.wstrb) >> cnb_pkg::CTRL_FNODE_LS);
          st_nxt.file_baud = 8'(merge(ctrl_q, st_r.wdata, st_r.wstrb) >> cnb_pkg::CTRL_FBAUD_LS);
          if (st_r.wstrb[0] && st_r.wdata[cnb_pkg::CTRL_RESET_B]) begin
            st_nxt.settle = cnb_pkg::SETTLE_CYC;
          end
        end
        cnb_pkg::OFF_REQ_LO:  st_nxt.req_lo = merge(st_r.req_lo, st_r.wdata, st_r.wstrb);
        cnb_pkg::OFF_REQ_HI:  st_nxt.req_hi = merge(st_r.req_hi, st_r.wdata, st_r.wstrb);
        cnb_pkg::OFF_STATUSW:
          st_nxt.statusw = 16'(merge({16'h0, st_r.statusw}, st_r.wdata, st_r.wstrb));
        cnb_pkg::OFF_ACTIVE, cnb_pkg::OFF_RESP_LO, cnb_pkg::OFF_RESP_HI: ;
        default: st_nxt.bresp = cnb_pkg::RESP_SLVERR;
      endcase
    end
    st_nxt.awready = !st_nxt.aw_full && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_full && !st_nxt.bvalid;
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_val;
      st_nxt.rresp = rd_hit ? cnb_pkg::RESP_OKAY : cnb_pkg::RESP_SLVERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = !st_nxt.rvalid;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign node_id = st_r.node;
  assign bit_rate_kbd = st_r.kbd;
  assign cfg_valid = st_r.valid;

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic [8:0] sel_sum = 9'(16 * st_r.sw_sync[7:4]) + {5'h0, st_r.sw_sync[3:0]};

  sequence s_apply_clean;
    apply && !st_r.stored_ok && !st_r.file_ok && sel == 8'h00;
  endsequence

  chk_default_ids: assert property (s_apply_clean
    |=> node_id == 7'h01 && bit_rate_kbd == 10'h3e8)
    else $error("default node or rate wrong");
  chk_selector_pack: assert property (apply && sel > 8'h00 && sel < 8'h80
    |=> node_id == {$past(st_r.sw_sync[6:4]), $past(st_r.sw_sync[3:0])})
    else $error("selector nibbles misplaced");
  chk_upper_weight: assert property (apply && sel > 8'h80
    |=> node_id == 7'($past(sel_sum) - 9'h080))
    else $error("upper switch not weighted by sixteen");
  chk_low_range: assert property (apply && sel > 8'h00 && sel < 8'h80 |=> bit_rate_kbd == 10'd1000)
    else $error("low selector rate not 1 Mbaud");
  chk_high_range: assert property (apply && sel > 8'h80
    |=> node_id == $past(sel[6:0]) && st_r.baud == $past(lay_baud))
    else $error("high selector mapping wrong");
  chk_zero_split: assert property (apply && (sel == 8'h00 || sel == 8'h80)
    |=> node_id == $past(lay_node))
    else $error("node object not used");
  chk_code_decode: assert property (apply && sel == 8'h80 && lay_baud == 8'h84
    |=> bit_rate_kbd == 10'd125)
    else $error("baud code 132 not 125 kBd");
  chk_hold_between: assert property (!apply |=> $stable(node_id) && $stable(bit_rate_kbd))
    else $error("settings changed without reset");
  chk_file_wins: assert property (apply && st_r.file_ok && sel[6:0] == 7'h00
    |=> node_id == $past(st_r.file_node))
    else $error("file value did not override");
  chk_status_reply: assert property (st_r.req_lo == 32'h00604140 && st_r.req_hi == 32'h0
    |=> st_r.resp_lo == 32'h0060414b && st_r.resp_hi[15:0] == $past(st_r.statusw))
    else $error("statusword answer wrong");
  chk_bad_code: assert property (apply && sel[7] && lay_baud == 8'h87
    |=> bit_rate_kbd == 10'd1000)
    else $error("unlisted code did not fall back");
endmodule
`default_nettype wire

// *** testbench/cnb_axi_master.sv ***
`timescale 1ns/10ps
`default_nettype none
module cnb_axi_master (
  input  wire logic        mclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Each channel drops its valid on its own handshake, so either order of acceptance works.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid  <= s_axi_wvalid && !s_axi_wready;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic store(input logic [31:0] sig, output logic [1:0] r);
    wr(cnb_pkg::OFF_STORE, sig, r);
  endtask
  task automatic ask_status(output logic [1:0] r);
    wr(cnb_pkg::OFF_REQ_LO, 32'h00604140, r);
    wr(cnb_pkg::OFF_REQ_HI, 32'h00000000, r);
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_can_node_baud_select.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module tb_can_node_baud_select;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  upper_digit_switch = 4'h0;
  logic [3:0]  lower_digit_switch = 4'h0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, dat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [6:0]  node_id;
  logic [9:0]  bit_rate_kbd;
  logic        cfg_valid;
  int          err_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #2 mclk = ~mclk;
  cnb_top dut (.mclk, .nrst, .upper_digit_switch, .lower_digit_switch,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .node_id, .bit_rate_kbd, .cfg_valid);
  cnb_axi_master m (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic wrap_up();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Sized well above the whole sequence so only a real hang trips it.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic obj(input logic [6:0] nd, input logic [7:0] bd);
    m.wr(cnb_pkg::OFF_NODE_OBJ, {25'h0, nd}, rsp);
    m.wr(cnb_pkg::OFF_BAUD_OBJ, {24'h0, bd}, rsp);
    m.store(32'h65766173, rsp);
  endtask
  // The switches are only taken over on the communication reset, so set them first.
  task automatic cfg(input logic [7:0] sel, input logic [31:0] ctrl);
    upper_digit_switch <= sel[7:4];
    lower_digit_switch <= sel[3:0];
    m.wr(cnb_pkg::OFF_CTRL, ctrl | 32'h00000001, rsp);
    repeat (4) @(posedge mclk);
  endtask
  task automatic t_default();
    `CHK(node_id, 7'h01, "default node")
    `CHK(bit_rate_kbd, 10'd1000, "default rate")
    `CHK(cfg_valid, 1'b1, "settings not applied")
  endtask
  task automatic t_direct();
    logic [7:0] sel [4] = '{8'h01, 8'h1f, 8'h7f, 8'hf0};
    logic [6:0] en [4] = '{7'h01, 7'h1f, 7'h7f, 7'h70};
    logic [9:0] ek [4] = '{10'd1000, 10'd1000, 10'd1000, 10'd10};
    obj(7'h05, 8'h81);
    foreach (sel[i]) begin
      cfg(sel[i], 32'h0);
      `CHK(node_id, en[i], "switch node")
      `CHK(bit_rate_kbd, ek[i], "switch rate")
    end
  endtask
  task automatic t_hold();
    upper_digit_switch <= 4'h2;
    lower_digit_switch <= 4'h2;
    repeat (10) @(posedge mclk);
    `CHK(node_id, 7'h70, "node changed without reset")
    cfg(8'h22, 32'h0);
    `CHK(node_id, 7'h22, "node after comm reset")
  endtask
  task automatic t_baud();
    logic [7:0] code [9] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h88, 8'h87, 8'h00};
    logic [9:0] ek [9] = '{10'd10, 10'd20, 10'd50, 10'd125, 10'd250, 10'd500, 10'd1000,
      10'd1000, 10'd1000};
    foreach (code[i]) begin
      obj(7'h05, code[i]);
      cfg(8'ha1, 32'h0);
      `CHK(node_id, 7'h21, "node from upper range")
      `CHK(bit_rate_kbd, ek[i], "baud code rate")
    end
  endtask
  task automatic t_layers();
    obj(7'h2a, 8'h83);
    cfg(8'h00, 32'h0);
    `CHK(node_id, 7'h2a, "selector 0 node")
    `CHK(bit_rate_kbd, 10'd1000, "selector 0 rate")
    cfg(8'h80, 32'h0);
    `CHK(bit_rate_kbd, 10'd50, "selector 128 rate")
    cfg(8'h80, 32'h00841102);
    `CHK(node_id, 7'h11, "file node over stored")
    `CHK(bit_rate_kbd, 10'd125, "file rate over stored")
    cfg(8'h05, 32'h00841102);
    `CHK(node_id, 7'h05, "switch over file")
    m.wr(cnb_pkg::OFF_NODE_OBJ, 32'h00000033, rsp);
    m.store(32'h12345678, rsp);
    cfg(8'h80, 32'h0);
    `CHK(node_id, 7'h2a, "store with bad signature")
  endtask
  // A power cycle loses the stored copy, so selector 128 falls back to the default layer.
  task automatic t_power();
    m.rd(cnb_pkg::OFF_STORE, dat, rsp);
    `CHK(dat, 32'h00000001, "stored copy flag")
    m.rd(cnb_pkg::OFF_ACTIVE, dat, rsp);
    `CHK(dat, 32'h0c81832a, "active settings word")
    nrst <= 1'b0;
    @(posedge mclk);
    `CHK(node_id, 7'h00, "node during reset")
    `CHK(cfg_valid, 1'b0, "valid during reset")
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK(cfg_valid, 1'b0, "settings applied too early")
    repeat (2) @(posedge mclk);
    `CHK(node_id, 7'h01, "node after power cycle")
    `CHK(bit_rate_kbd, 10'h3e8, "rate after power cycle")
  endtask
  task automatic t_sdo();
    m.ask_status(rsp);
    m.wr(cnb_pkg::OFF_STATUSW, 32'h00001234, rsp);
    `CHK(rsp, 2'h0, "mapped write response")
    repeat (2) @(posedge mclk);
    m.rd(cnb_pkg::OFF_RESP_LO, dat, rsp);
    `CHK(dat, 32'h0060414b, "status answer head")
    m.rd(cnb_pkg::OFF_RESP_HI, dat, rsp);
    `CHK(dat, 32'h00001234, "status answer tail")
    m.rd(8'h3c, dat, rsp);
    `CHK(rsp, 2'h2, "unmapped read response")
    `CHK(dat, 32'h0, "unmapped read data")
    m.wr(8'h3c, 32'h1, rsp);
    `CHK(rsp, 2'h2, "unmapped write response")
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    t_default();
    t_direct();
    t_hold();
    t_baud();
    t_layers();
    t_power();
    t_sdo();
    wrap_up();
  end
endmodule
`default_nettype wire
